// ==== verilog/scc_regs.sv ====
// Purpose: Synthesizer channel configuration register bank on AXI4-Lite
// Assumes: Single clock, synchronous active-high reset
// Notes: Transmit command picks the active channel and wakes from standby
module scc_regs
   import scc_pkg::*;
(
   input logic clk,
   input logic rst,
   // AXI4-Lite write address
   input logic awvalid,
   output logic awready,
   input logic [ADDR_W-1:0] awaddr,
   input logic [2:0] awprot,
   // AXI4-Lite write data
   input logic wvalid,
   output logic wready,
   input logic [DATA_W-1:0] wdata,
   input logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input logic arvalid,
   output logic arready,
   input logic [ADDR_W-1:0] araddr,
   input logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input logic rready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // Transmit command
   input logic tx_cmd_valid,
   input logic [1:0] tx_cmd_chan,
   // Synthesizer side
   output logic [1:0] band_select,
   output logic failsafe_request,
   output logic standby_request,
   output logic standby_active,
   output logic [1:0] active_chan,
   output logic [INT_W-1:0] int_ratio_value,
   output logic [BYTE_W-1:0] frac_low_byte
);
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [DATA_W-1:0] rdata_q;
   logic aw_full_q, w_full_q;
   logic [IDX_W-1:0] wr_idx_q;
   logic [DATA_W-1:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   logic wr_cfg, wr_chan, wr_is_int;
   logic [1:0] wr_ch;
   logic rd_cfg, rd_chan, rd_is_int, rd_stat;
   logic [1:0] rd_ch;
   logic rd_cfg_q, rd_chan_q, rd_stat_q, rd_hit_q, rd_int_q;
   scc_rd_state_t rd_state_q;
   logic [7:0] cfg_q;
   logic standby_req_q, standby_q;
   logic [1:0] chan_q;
   logic [INT_W-1:0] act_int_q;
   logic [BYTE_W-1:0] act_frac_q;
   logic [7:0] store_rd;
   logic [NUM_CHAN*INT_W-1:0] int_flat;
   logic [NUM_CHAN*BYTE_W-1:0] frac_flat;
   logic [IDX_W-1:0] ar_idx;

   // Port outputs straight from flops
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign band_select = cfg_q[CFG_BAND_LSB +: 2];
   assign failsafe_request = cfg_q[CFG_FS_BIT];
   assign standby_request = standby_req_q;
   assign standby_active = standby_q;
   assign active_chan = chan_q;
   assign int_ratio_value = act_int_q;
   assign frac_low_byte = act_frac_q;

   // Write accepted once both address and data are held
   assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
   assign ar_idx = araddr[ADDR_W-1:2];

   // Write address decode
   always_comb begin
      wr_cfg = (wr_idx_q == IDX_TX_CONFIG_0);
      wr_chan = 1'b0;
      wr_is_int = 1'b0;
      wr_ch = 2'h0;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (wr_idx_q == IDX_INT[i] || wr_idx_q == IDX_FRAC[i]) begin
            wr_chan = 1'b1;
            wr_is_int = (wr_idx_q == IDX_INT[i]);
            wr_ch = 2'(i);
         end
      end
   end

   // Read address decode
   always_comb begin
      rd_cfg = (ar_idx == IDX_TX_CONFIG_0);
      rd_stat = (ar_idx == IDX_STATUS);
      rd_chan = 1'b0;
      rd_is_int = 1'b0;
      rd_ch = 2'h0;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (ar_idx == IDX_INT[i] || ar_idx == IDX_FRAC[i]) begin
            rd_chan = 1'b1;
            rd_is_int = (ar_idx == IDX_INT[i]);
            rd_ch = 2'(i);
         end
      end
   end

   // Write address channel
   always_ff @(posedge clk) begin
      if (rst) begin
         awready_q <= 1'b1;
         aw_full_q <= 1'b0;
         wr_idx_q <= '0;
      end else if (awvalid && awready_q) begin
         awready_q <= 1'b0;
         aw_full_q <= 1'b1;
         wr_idx_q <= awaddr[ADDR_W-1:2];
      end else if (bvalid_q && bready) begin
         awready_q <= 1'b1;
         aw_full_q <= 1'b0;
      end
   end

   // Write data channel
   always_ff @(posedge clk) begin
      if (rst) begin
         wready_q <= 1'b1;
         w_full_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= 4'h0;
      end else if (wvalid && wready_q) begin
         wready_q <= 1'b0;
         w_full_q <= 1'b1;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else if (bvalid_q && bready) begin
         wready_q <= 1'b1;
         w_full_q <= 1'b0;
      end
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= (wr_cfg || wr_chan) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Configuration register; the standby bit is never stored
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_q <= CFG_RESET & 8'h7f;
      end else if (wr_fire && wr_cfg && wstrb_q[0]) begin
         cfg_q <= {1'b0, wdata_q[6:0]};
      end
   end

   // Standby request pulse and standby state; request wins over wake
   always_ff @(posedge clk) begin
      if (rst) begin
         standby_req_q <= 1'b0;
         standby_q <= 1'b0;
      end else begin
         standby_req_q <= wr_fire && wr_cfg && wstrb_q[0] && wdata_q[CFG_STBY_BIT];
         if (wr_fire && wr_cfg && wstrb_q[0] && wdata_q[CFG_STBY_BIT]) begin
            standby_q <= 1'b1;
         end else if (tx_cmd_valid) begin
            standby_q <= 1'b0;
         end
      end
   end

   // Transmit command picks the active channel
   always_ff @(posedge clk) begin
      if (rst) begin
         chan_q <= 2'h0;
      end else if (tx_cmd_valid) begin
         chan_q <= tx_cmd_chan;
      end
   end

   // Active channel division values for the modulator
   always_ff @(posedge clk) begin
      if (rst) begin
         act_int_q <= INT_RESET;
         act_frac_q <= FRAC_RESET;
      end else begin
         act_int_q <= int_flat[chan_q*INT_W +: INT_W];
         act_frac_q <= frac_flat[chan_q*BYTE_W +: BYTE_W];
      end
   end

   // Read channel state machine
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_state_q <= RD_IDLE;
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
         rd_cfg_q <= 1'b0;
         rd_chan_q <= 1'b0;
         rd_stat_q <= 1'b0;
         rd_hit_q <= 1'b0;
         rd_int_q <= 1'b0;
      end else begin
         case (rd_state_q)
            RD_IDLE: begin
               if (arvalid && arready_q) begin
                  arready_q <= 1'b0;
                  rd_cfg_q <= rd_cfg;
                  rd_chan_q <= rd_chan;
                  rd_stat_q <= rd_stat;
                  rd_int_q <= rd_chan && rd_is_int;
                  rd_state_q <= RD_FETCH;
               end
            end
            RD_FETCH: begin
               rvalid_q <= 1'b1;
               rd_hit_q <= rd_int_q;
               rresp_q <= (rd_cfg_q || rd_chan_q || rd_stat_q) ? RESP_OKAY : RESP_SLVERR;
               if (rd_cfg_q) begin
                  rdata_q <= {24'h0, cfg_q};
               end else if (rd_chan_q) begin
                  rdata_q <= {24'h0, store_rd};
               end else if (rd_stat_q) begin
                  rdata_q <= {26'h0, chan_q, cfg_q[CFG_BAND_LSB +: 2],
                              cfg_q[CFG_FS_BIT], standby_q};
               end else begin
                  rdata_q <= '0;
               end
               rd_state_q <= RD_RESP;
            end
            RD_RESP: begin
               if (rready) begin
                  rvalid_q <= 1'b0;
                  arready_q <= 1'b1;
                  rd_state_q <= RD_IDLE;
               end
            end
            default: begin
               rd_state_q <= RD_IDLE;
               arready_q <= 1'b1;
               rvalid_q <= 1'b0;
            end
         endcase
      end
   end

   // Channel register storage
   scc_chan_store #(.NCH(NUM_CHAN)) u_store (
      .clk(clk),
      .rst(rst),
      .wr_en(wr_fire && wr_chan && wstrb_q[0]),
      .wr_ch(wr_ch),
      .wr_is_int(wr_is_int),
      .wr_data(wdata_q[7:0]),
      .rd_en(arvalid && arready_q && rd_state_q == RD_IDLE),
      .rd_ch(rd_ch),
      .rd_is_int(rd_is_int),
      .rd_data_q(store_rd),
      .int_flat(int_flat),
      .frac_flat(frac_flat)
   );

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic cfg_wr_now, int_wr_now, frac_wr_now;
   logic [NUM_CHAN*INT_W-1:0] keep_mask;
   assign cfg_wr_now = wr_fire && wr_cfg && wstrb_q[0];
   assign int_wr_now = wr_fire && wr_chan && wr_is_int && wstrb_q[0];
   assign frac_wr_now = wr_fire && wr_chan && !wr_is_int && wstrb_q[0];

   // Bits of channels other than the one being written
   always_comb begin
      keep_mask = '1;
      keep_mask[wr_ch*INT_W +: INT_W] = '0;
   end

   sequence s_cfg_write;
      cfg_wr_now;
   endsequence

   sequence s_cmd_hold;
      tx_cmd_valid ##1 !tx_cmd_valid [*2];
   endsequence

   a_band_field: assert property (s_cfg_write |=>
      band_select == $past(wdata_q[3:2]) && cfg_q[7] == 1'b0)
      else $error("band select not taken from config write");

   a_chan_separate: assert property (int_wr_now |=>
      ((int_flat ^ $past(int_flat)) & $past(keep_mask)) == '0)
      else $error("integer write disturbed another channel");

   a_int_upper_zero: assert property (rvalid_q && rd_hit_q |->
      rdata_q[31:7] == '0)
      else $error("integer register read shows bits above 6");

   a_frac_byte: assert property (frac_wr_now |=>
      frac_flat[$past(wr_ch)*BYTE_W +: BYTE_W] == $past(wdata_q[7:0]))
      else $error("fractional low byte not stored");

   a_stby_pulse: assert property (s_cfg_write ##0 wdata_q[CFG_STBY_BIT] |=>
      standby_request && standby_active ##1 !standby_request)
      else $error("standby request not a one-cycle pulse");

   a_fs_enter: assert property (s_cfg_write |=>
      failsafe_request == $past(wdata_q[CFG_FS_BIT]))
      else $error("failsafe request not taken");

   a_active_chan: assert property (s_cmd_hold |->
      active_chan == $past(tx_cmd_chan, 2) &&
      int_ratio_value == $past(int_flat[chan_q*INT_W +: INT_W]))
      else $error("active channel values not selected");

   a_bresp_time: assert property (awvalid && awready && wvalid && wready |->
      !bvalid ##2 bvalid)
      else $error("write response not two cycles after handshake");
endmodule

// ==== verilog/scc_pkg.sv ====
// Purpose: Constants and types for the synthesizer channel configuration registers
// Assumes: AXI4-Lite slave with 32-bit data, register index = byte address / 4
// Notes: Summary of operation follows
// Summary of operation
// - The transmitter configuration register holds a 2-bit band select in bits 3:2.
// - Four separate integer division registers exist, one each for channels A to D.
// - Each integer register holds 7 bits in 6:0, bit 7 reads zero, reset sets bit 6 only.
// - Each channel has a fractional low byte register at index 0x0A/0x0E/0x12/0x16, reset 0.
// - The synthesizer uses the integer and fractional values of the channel the transmit command picks.
package scc_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned IDX_W = 6;
   localparam int unsigned NUM_CHAN = 4;
   localparam int unsigned INT_W = 7;
   localparam int unsigned BYTE_W = 8;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_TX_CONFIG_0 = 6'h04;
   localparam logic [5:0] IDX_INT [NUM_CHAN] = '{6'h09, 6'h0d, 6'h11, 6'h15};
   localparam logic [5:0] IDX_FRAC [NUM_CHAN] = '{6'h0a, 6'h0e, 6'h12, 6'h16};
   localparam logic [5:0] IDX_STATUS = 6'h1c;
   // Configuration register fields
   localparam int unsigned CFG_STBY_BIT = 7;
   localparam int unsigned CFG_FS_BIT = 4;
   localparam int unsigned CFG_BAND_LSB = 2;
   localparam logic [7:0] CFG_RESET = 8'h06;
   // Channel register reset values
   localparam logic [6:0] INT_RESET = 7'h40;
   localparam logic [7:0] FRAC_RESET = 8'h00;
   // Status register fields
   localparam int unsigned STAT_STBY_BIT = 0;
   localparam int unsigned STAT_FS_BIT = 1;
   localparam int unsigned STAT_BAND_LSB = 2;
   localparam int unsigned STAT_CHAN_LSB = 4;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} scc_rd_state_t;
endpackage

// ==== verilog/scc_chan_store.sv ====
// Purpose: Per-channel integer and fractional low byte storage
// Assumes: One write and one read port, read data registered
// Notes: All channel values are also presented in parallel
module scc_chan_store
   import scc_pkg::*;
#(
   parameter int unsigned NCH = NUM_CHAN
) (
   input logic clk,
   input logic rst,
   input logic wr_en,
   input logic [1:0] wr_ch,
   input logic wr_is_int,
   input logic [7:0] wr_data,
   input logic rd_en,
   input logic [1:0] rd_ch,
   input logic rd_is_int,
   output logic [7:0] rd_data_q,
   output logic [NCH*INT_W-1:0] int_flat,
   output logic [NCH*BYTE_W-1:0] frac_flat
);
   // One integer and one fractional register per channel
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_chan
         logic [6:0] int_q;
         logic [7:0] frac_q;
         always_ff @(posedge clk) begin
            if (rst) begin
               int_q <= INT_RESET;
               frac_q <= FRAC_RESET;
            end else if (wr_en && wr_ch == 2'(g)) begin
               if (wr_is_int) begin
                  int_q <= wr_data[6:0];
               end else begin
                  frac_q <= wr_data;
               end
            end
         end
         assign int_flat[g*INT_W +: INT_W] = int_q;
         assign frac_flat[g*BYTE_W +: BYTE_W] = frac_q;
      end
   endgenerate

   // Registered read; bit 7 of an integer register reads zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_q <= 8'h00;
      end else if (rd_en) begin
         if (rd_is_int) begin
            rd_data_q <= {1'b0, int_flat[rd_ch*INT_W +: INT_W]};
         end else begin
            rd_data_q <= frac_flat[rd_ch*BYTE_W +: BYTE_W];
         end
      end
   end
endmodule

// ==== test/scc_host_model.sv ====
// Purpose: AXI4-Lite host that writes and reads the configuration registers
// Assumes: Signals change by non-blocking assignment just after a rising edge
// Notes: Released payload is inverted so a stale value never passes for a live one
module scc_host_model (
   input logic clk,
   output logic awvalid,
   input logic awready,
   output logic [7:0] awaddr,
   output logic [2:0] awprot,
   output logic wvalid,
   input logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input logic bvalid,
   output logic bready,
   input logic [1:0] bresp,
   output logic arvalid,
   input logic arready,
   output logic [7:0] araddr,
   output logic [2:0] arprot,
   input logic rvalid,
   output logic rready,
   input logic [31:0] rdata,
   input logic [1:0] rresp
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, awprot, arprot} = 22'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
   end
   // One write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw_ok;
      bit w_ok;
      aw_ok = 0;
      w_ok = 0;
      r = 2'h3;
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (aw_ok && w_ok && bvalid) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
         if (!aw_ok && awready) begin
            aw_ok = 1;
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (!w_ok && wready) begin
            w_ok = 1;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      @(posedge clk);
   endtask
   // One read: address held until taken, data taken with rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ar_ok;
      ar_ok = 0;
      r = 2'h3;
      d = 32'hdead_beef;
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (ar_ok && rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
         if (!ar_ok && arready) begin
            ar_ok = 1;
            arvalid <= 1'b0;
            araddr <= ~a;
         end
      end
      @(posedge clk);
   endtask
endmodule

// ==== test/synth_channel_config_regs_tb.sv ====
// Purpose: Self-checking bench for the channel configuration register bank
// Assumes: Host model drives the register bus, bench drives transmit commands
// Notes: Each scenario is one task that judges its own results
module synth_channel_config_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import scc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, band_select, active_chan;
   logic tx_cmd_valid = 1'b0;
   logic [1:0] tx_cmd_chan = 2'h0;
   logic failsafe_request, standby_request, standby_active;
   logic [INT_W-1:0] int_ratio_value;
   logic [BYTE_W-1:0] frac_low_byte;
   int mismatches = 0;
   int comparisons = 0;
   int stby_pulses = 0;
   // Clock at 40 MHz
   always #12.5 clk = ~clk;
   scc_regs dut_u (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .tx_cmd_valid(tx_cmd_valid), .tx_cmd_chan(tx_cmd_chan),
      .band_select(band_select), .failsafe_request(failsafe_request),
      .standby_request(standby_request), .standby_active(standby_active),
      .active_chan(active_chan), .int_ratio_value(int_ratio_value),
      .frac_low_byte(frac_low_byte));
   scc_host_model host_u (.clk(clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp));
   // Counts cycles with the standby pulse high
   always @(posedge clk) begin
      if (standby_request === 1'b1) stby_pulses <= stby_pulses + 1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr_chk(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      host_u.wr({idx, 2'b00}, d, r);
      chk(32'(r), 32'(er), "write response");
   endtask
   task automatic rd_chk(input logic [5:0] idx, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      host_u.rd({idx, 2'b00}, d, r);
      chk(32'(r), 32'(er), "read response");
      chk(d, e, "read data");
   endtask
   task automatic tx_cmd(input logic [1:0] c);
      tx_cmd_valid <= 1'b1;
      tx_cmd_chan <= c;
      @(posedge clk);
      tx_cmd_valid <= 1'b0;
      tx_cmd_chan <= ~c;
      repeat (3) @(posedge clk);
   endtask
   // Reset values at the bus and at the synthesizer side
   task automatic t_reset;
      rd_chk(IDX_TX_CONFIG_0, 32'h06, RESP_OKAY);
      chk(32'(band_select), 32'h1, "band after reset");
      chk(32'(int_ratio_value), 32'h40, "int after reset");
      chk(32'(frac_low_byte), 32'h0, "frac after reset");
      for (int c = 0; c < 4; c++) begin
         rd_chk(IDX_INT[c], 32'h40, RESP_OKAY);
         rd_chk(IDX_FRAC[c], 32'h00, RESP_OKAY);
      end
   endtask
   // Every band code reaches the output and reads back
   task automatic t_band;
      for (int b = 0; b < 4; b++) begin
         wr_chk(IDX_TX_CONFIG_0, 32'(b) << 2, RESP_OKAY);
         chk(32'(band_select), 32'(b), "band output");
         rd_chk(IDX_TX_CONFIG_0, 32'(b) << 2, RESP_OKAY);
      end
   endtask
   // Four channels hold distinct values; the transmit command picks one
   task automatic t_chan;
      logic [6:0] iv [4] = '{7'd54, 7'd60, 7'd70, 7'd84};
      logic [7:0] fv [4] = '{8'h11, 8'h5a, 8'ha5, 8'hff};
      wr_chk(IDX_TX_CONFIG_0, 32'h0c, RESP_OKAY);
      for (int c = 0; c < 4; c++) begin
         wr_chk(IDX_INT[c], {24'h0, 1'b1, iv[c]}, RESP_OKAY);
         wr_chk(IDX_FRAC[c], {24'h0, fv[c]}, RESP_OKAY);
      end
      for (int c = 3; c >= 0; c--) begin
         rd_chk(IDX_INT[c], {25'h0, iv[c]}, RESP_OKAY);
         rd_chk(IDX_FRAC[c], {24'h0, fv[c]}, RESP_OKAY);
         tx_cmd(2'(c));
         chk(32'(active_chan), 32'(c), "active channel");
         chk(32'(int_ratio_value), 32'(iv[c]), "active int");
         chk(32'(frac_low_byte), 32'(fv[c]), "active frac");
      end
   endtask
   // Standby pulse, self clearing bit, wake by transmit, failsafe level
   task automatic t_standby;
      int p0;
      p0 = stby_pulses;
      wr_chk(IDX_TX_CONFIG_0, 32'h84, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(32'(stby_pulses - p0), 32'h1, "standby pulse count");
      chk(32'(standby_active), 32'h1, "standby entered");
      rd_chk(IDX_TX_CONFIG_0, 32'h04, RESP_OKAY);
      // Status: channel A active, band 01, failsafe off, standby on
      rd_chk(IDX_STATUS, 32'h05, RESP_OKAY);
      tx_cmd(2'h1);
      chk(32'(standby_active), 32'h0, "standby left");
      wr_chk(IDX_TX_CONFIG_0, 32'h14, RESP_OKAY);
      chk(32'(failsafe_request), 32'h1, "failsafe set");
      wr_chk(IDX_TX_CONFIG_0, 32'h04, RESP_OKAY);
      chk(32'(failsafe_request), 32'h0, "failsafe clear");
   endtask
   // Upper fractional byte slot is unmapped and leaves byte 0 alone
   task automatic t_unmapped;
      wr_chk(IDX_FRAC[0], 32'h3c, RESP_OKAY);
      wr_chk(6'h0b, 32'hc3, RESP_SLVERR);
      rd_chk(6'h0b, 32'h0, RESP_SLVERR);
      rd_chk(IDX_FRAC[0], 32'h3c, RESP_OKAY);
      wr_chk(IDX_STATUS, 32'h0, RESP_SLVERR);
      // A write without byte 0 enabled leaves the register alone
      host_u.wstrb <= 4'he;
      wr_chk(IDX_FRAC[0], 32'h99, RESP_OKAY);
      host_u.wstrb <= 4'hf;
      rd_chk(IDX_FRAC[0], 32'h3c, RESP_OKAY);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_band();
      t_chan();
      t_standby();
      t_unmapped();
      // Second reset in mid-run must restore every reset value
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      print_verdict();
   end
   // Watchdog well past the expected run of a few hundred cycles
   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end
endmodule
